// ### slpr_device.sv
// Serial channel 0 end: slave receive with low-power receive mode, master
// transfer clock generation. Assumes the serial clock pin is asynchronous.
`timescale 1ns/1ps
// Summary of operation
// - Low-power receive only on channel zero.
// - Stop mode without wake halts communication; shifting stops, but the master clock keeps running.
// - Software sets wake before stop, start after setup.
// - Clock edge in stop enters low-power receive.
// - Low-power receive needs high-speed oscillator clock.
// - Master rate at most 1 Mbps there.
// - Read data while wake set, before next edge.
// - Stop bit written before and after; clears enabled.
// - Software clears wake to leave low-power receive.
// - Wake set freezes channel one full/overrun flags.
// - Master clock is mck over (div+1) over 2.
// - Divider field seven bits, zero to 127.
// - Slave clock at most mck over six.
// - Mode bit 15 selects prescaler output.
// - Prescaler field k gives clock over 2^k.
// - Stop all channels before changing clock source.
// - Full flag plus new reception sets overrun.
module slpr_device (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Link
	slpr_link_if.dev link,
	// Power state
	input wire logic stop_mode,
	input wire logic hs_osc_selected,
	// Software controls
	input wire logic wake_enable_bit,
	input wire logic channel_start_bit,
	input wire logic channel_stop_bit,
	input wire logic [3:0] channel_stop_reg,
	input wire logic master_mode,
	input wire logic [15:0] channel_mode_reg,
	input wire logic [7:0] prescaler_select_reg,
	input wire logic [15:0] channel_data_wr,
	input wire logic data_wr,
	input wire logic data_rd,
	// Channel 1 events
	input wire logic ch1_rx_done,
	input wire logic ch1_data_rd,
	// Status
	output logic channel_enabled_flag,
	output logic buffer_full_flag,
	output logic overrun_flag,
	output logic ch1_buffer_full_flag,
	output logic ch1_overrun_flag,
	output logic low_power_receive_mode,
	output logic wake_cpu,
	output logic [7:0] rx_data,
	output logic [15:0] channel_data_reg,
	output logic sck_out,
	output logic sck_oe
);
	logic sck_m_ff;
	logic sck_s_ff;
	logic sck_d_ff;
	logic sdi_m_ff;
	logic sdi_s_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [2:0] nxt_bit_cnt;
	logic rise;
	logic rx_done;
	logic active;
	logic mck_en;
	logic half_en;
	logic sdo_ff;
	slpr_pkg::slpr_pmode_type pmode_ff;

	// ----------------------------------------
	// Clock generation
	// ----------------------------------------
	slpr_clkgen u_clkgen (
		.core_clk(core_clk),
		.nrst(nrst),
		.clock_source_select(channel_mode_reg[slpr_pkg::CKS_BIT]),
		.prescaler_low_field(prescaler_select_reg[3:0]),
		.prescaler_high_field(prescaler_select_reg[7:4]),
		.div_field(channel_data_reg[slpr_pkg::DIV_MSB:slpr_pkg::DIV_LSB]),
		.run(channel_enabled_flag && master_mode),
		.mck_en(mck_en),
		.half_en(half_en)
	);

	// ----------------------------------------
	// Serial clock sync; first stage read only by second
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sck_m_ff <= 1'b0;
			sck_s_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			sdi_m_ff <= 1'b0;
			sdi_s_ff <= 1'b0;
		end else begin
			sck_m_ff <= link.sck;
			sck_s_ff <= sck_m_ff;
			sck_d_ff <= sck_s_ff;
			// Data takes the same two stages so it lines up with the rise
			sdi_m_ff <= link.sdi;
			sdi_s_ff <= sdi_m_ff;
		end
	end

	// Sampled pin is why the slave clock is limited to mck/6
	assign rise = sck_s_ff && !sck_d_ff && !master_mode;

	// ----------------------------------------
	// Power mode
	// ----------------------------------------
	// This is channel zero: only it offers the low-power path
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pmode_ff <= slpr_pkg::ST_RUN;
		end else begin
			unique case (pmode_ff)
				slpr_pkg::ST_RUN: begin
					if (stop_mode) begin
						pmode_ff <= slpr_pkg::ST_STOP;
					end
				end
				slpr_pkg::ST_STOP: begin
					if (!stop_mode) begin
						pmode_ff <= slpr_pkg::ST_RUN;
					end else if (wake_enable_bit && hs_osc_selected && rise) begin
						pmode_ff <= slpr_pkg::ST_LPRX;
					end
				end
				slpr_pkg::ST_LPRX: begin
					if (!wake_enable_bit) begin
						pmode_ff <= slpr_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	// Without wake, stop mode freezes all shifting
	assign active = channel_enabled_flag &&
		(pmode_ff != slpr_pkg::ST_STOP || wake_enable_bit);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			low_power_receive_mode <= 1'b0;
		end else begin
			low_power_receive_mode <= (pmode_ff == slpr_pkg::ST_LPRX);
		end
	end

	// ----------------------------------------
	// Channel enable
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			channel_enabled_flag <= 1'b0;
		end else if (channel_stop_bit || channel_stop_reg[0]) begin
			channel_enabled_flag <= 1'b0;
		end else if (channel_start_bit) begin
			channel_enabled_flag <= 1'b1;
		end
	end

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	assign nxt_bit_cnt = bit_cnt_ff + 3'h1;
	assign rx_done = active && rise && bit_cnt_ff == 3'h7;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shift_ff <= 8'h00;
			bit_cnt_ff <= slpr_pkg::BIT_CNT_RST;
		end else if (!channel_enabled_flag) begin
			bit_cnt_ff <= slpr_pkg::BIT_CNT_RST;
		end else if (active && rise) begin
			shift_ff <= {shift_ff[6:0], sdi_s_ff};
			bit_cnt_ff <= nxt_bit_cnt;
		end
	end

	// Master clock toggles on each half enable
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
		end else begin
			sck_oe <= master_mode && channel_enabled_flag;
			if (half_en) begin
				sck_out <= !sck_out;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sdo_ff <= 1'b0;
		end else begin
			sdo_ff <= shift_ff[7];
		end
	end
	assign link.sdo = sdo_ff;

	// ----------------------------------------
	// Data register and flags
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			channel_data_reg <= slpr_pkg::DATA_REG_RST;
			rx_data <= 8'h00;
		end else if (rx_done) begin
			rx_data <= {shift_ff[6:0], sdi_s_ff};
			channel_data_reg[7:0] <= {shift_ff[6:0], sdi_s_ff};
		end else if (data_wr) begin
			channel_data_reg <= channel_data_wr;
		end
	end

	// Set wins over read-clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			buffer_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
		end else begin
			if (rx_done) begin
				buffer_full_flag <= 1'b1;
			end else if (data_rd) begin
				buffer_full_flag <= 1'b0;
			end
			if (rx_done && buffer_full_flag && !data_rd) begin
				overrun_flag <= 1'b1;
			end
		end
	end

	// Transfer-end wake only in run; low-power receive keeps the cpu asleep
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wake_cpu <= 1'b0;
		end else begin
			wake_cpu <= rx_done && pmode_ff == slpr_pkg::ST_RUN;
		end
	end

	// ----------------------------------------
	// Channel 1 flags, frozen while wake set
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ch1_buffer_full_flag <= 1'b0;
			ch1_overrun_flag <= 1'b0;
		end else if (!wake_enable_bit) begin
			if (ch1_rx_done) begin
				ch1_buffer_full_flag <= 1'b1;
			end else if (ch1_data_rd) begin
				ch1_buffer_full_flag <= 1'b0;
			end
			if (ch1_rx_done && ch1_buffer_full_flag && !ch1_data_rd) begin
				ch1_overrun_flag <= 1'b1;
			end
		end
	end
endmodule : slpr_device

// ### slpr_pkg.sv
// Package for the low-power serial receive channel and its clock generator.
// Assumes a single 20 MHz core clock; all slower rates are enable pulses.
package slpr_pkg;
	// ----------------------------------------
	// Widths and field positions
	// ----------------------------------------
	localparam int DIV_W = 7;
	localparam int DIV_LSB = 9;
	localparam int DIV_MSB = 15;
	localparam int PRS_W = 4;
	localparam int CKS_BIT = 15;
	localparam int DATA_W = 8;
	localparam int DATA_REG_W = 16;
	localparam int CH_COUNT = 4;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [DATA_REG_W-1:0] DATA_REG_RST = 16'h0000;
	localparam logic [15:0] MODE_REG_RST = 16'h0000;
	localparam logic [7:0] PRESCALE_RST = 8'h00;
	localparam logic [3:0] STOP_ALL = 4'hf;
	localparam logic [2:0] BIT_CNT_RST = 3'h0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CORE_HZ = 20000000;
	localparam int LP_MAX_BPS = 1000000;
	localparam int SLAVE_RATIO = 6;
	// Least master half-period in core cycles at the low-power rate limit
	localparam int LP_HALF_CYC = (CORE_HZ + 2 * LP_MAX_BPS - 1) / (2 * LP_MAX_BPS);
	typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_LPRX} slpr_pmode_type;
endpackage : slpr_pkg

// ### slpr_link_if.sv
// Interface joining the serial channel to the external master.
// Assumes both ends share core_clk; no clocking block.
`timescale 1ns/1ps
interface slpr_link_if;
	logic sck;
	logic sdi;
	logic sdo;
	modport dev (input sck, input sdi, output sdo);
	modport mst (output sck, output sdi, input sdo);
endinterface : slpr_link_if

// ### slpr_clkgen.sv
// Operating clock prescaler and master transfer-clock divider.
// Assumes one core clock; outputs are one-cycle enable pulses.
`timescale 1ns/1ps
module slpr_clkgen (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Configuration
	input wire logic clock_source_select,
	input wire logic [3:0] prescaler_low_field,
	input wire logic [3:0] prescaler_high_field,
	input wire logic [6:0] div_field,
	input wire logic run,
	// Enables
	output logic mck_en,
	output logic half_en
);
	logic [15:0] pre_cnt_ff;
	logic [6:0] div_cnt_ff;
	logic [3:0] sel_k;
	logic [15:0] mask;
	logic nxt_mck;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	assign sel_k = clock_source_select ? prescaler_high_field : prescaler_low_field;
	assign mask = 16'((32'h1 << sel_k) - 32'h1);
	assign nxt_mck = (pre_cnt_ff & mask) == 16'h0000;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt_ff <= 16'h0000;
		end else begin
			pre_cnt_ff <= pre_cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mck_en <= 1'b0;
		end else begin
			mck_en <= nxt_mck;
		end
	end

	// ----------------------------------------
	// Transfer divider: one half period each (div+1) mck ticks
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_ff <= 7'h00;
			half_en <= 1'b0;
		end else if (!run) begin
			div_cnt_ff <= 7'h00;
			half_en <= 1'b0;
		end else if (mck_en) begin
			half_en <= (div_cnt_ff == div_field);
			div_cnt_ff <= (div_cnt_ff == div_field) ? 7'h00 : div_cnt_ff + 7'h01;
		end else begin
			half_en <= 1'b0;
		end
	end
endmodule : slpr_clkgen

// ### slpr_master.sv
// External master end: drives the serial clock and a data bit.
// Assumes the same core clock; half period set by a parameter.
`timescale 1ns/1ps
module slpr_master #(
	parameter int HALF_CYC = slpr_pkg::LP_HALF_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Link
	slpr_link_if.mst link,
	// User side
	input wire logic start,
	input wire logic [7:0] tx_byte,
	output logic busy
);
	logic [15:0] cnt_ff;
	logic [4:0] edge_cnt_ff;
	logic sck_ff;
	logic [7:0] tx_ff;

	// Default half period never below the 1 Mbps limit; HALF_CYC itself is not checked
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 16'h0000;
			edge_cnt_ff <= 5'h00;
			sck_ff <= 1'b0;
			busy <= 1'b0;
		end else if (!busy) begin
			if (start) begin
				busy <= 1'b1;
				cnt_ff <= 16'h0000;
				edge_cnt_ff <= 5'h00;
			end
		end else if (cnt_ff == 16'(HALF_CYC - 1)) begin
			cnt_ff <= 16'h0000;
			sck_ff <= !sck_ff;
			edge_cnt_ff <= edge_cnt_ff + 5'h01;
			if (edge_cnt_ff == 5'h0f) begin
				busy <= 1'b0;
			end
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	assign link.sck = sck_ff;

	// Data moves on the falling edge so it is settled at every rise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_ff <= 8'h00;
		end else if (!busy && start) begin
			tx_ff <= tx_byte;
		end else if (busy && sck_ff && cnt_ff == 16'(HALF_CYC - 1)) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end
	assign link.sdi = tx_ff[7];
endmodule : slpr_master

// ### slpr_checker.sv
// Checker for the serial link, master handshake and receive status flags.
// Assumes one instance beside the link interface in tb_top, one clock domain.
`timescale 1ns/1ps
module slpr_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Link and master
	input wire logic sck,
	input wire logic start,
	input wire logic busy,
	// Device status
	input wire logic stop_mode,
	input wire logic wake_enable_bit,
	input wire logic buffer_full_flag,
	input wire logic overrun_flag,
	input wire logic ch1_buffer_full_flag,
	input wire logic ch1_overrun_flag,
	input wire logic low_power_receive_mode,
	input wire logic wake_cpu
);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_halted; (stop_mode && !wake_enable_bit)[*4]; endsequence
	sequence s_woken; wake_enable_bit[*2]; endsequence
	property p_sck_hold; $changed(sck) |=> $stable(sck)[*8]; endproperty
	property p_idle_low; !busy && !$past(busy) |-> !sck; endproperty
	property p_start_busy; start && !busy |=> busy[*8]; endproperty
	property p_ch1_freeze; s_woken |-> $stable(ch1_buffer_full_flag) && $stable(ch1_overrun_flag);
	endproperty
	property p_ovf_sticky; overrun_flag |=> overrun_flag; endproperty
	property p_ovf_cause; $rose(overrun_flag) |-> $past(buffer_full_flag); endproperty
	property p_lp_quiet; low_power_receive_mode |-> !wake_cpu; endproperty
	property p_stop_halt; s_halted |-> !$rose(buffer_full_flag); endproperty
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sck_hold: assert property (p_sck_hold) else $error("clock edge too soon");
	a_idle_low: assert property (p_idle_low) else $error("clock not idle low");
	a_start_busy: assert property (p_start_busy) else $error("start not taken");
	a_ch1_freeze: assert property (p_ch1_freeze) else $error("ch1 flag moved");
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overrun lost");
	a_ovf_cause: assert property (p_ovf_cause) else $error("overrun uncaused");
	a_lp_quiet: assert property (p_lp_quiet) else $error("cpu woken");
	a_stop_halt: assert property (p_stop_halt) else $error("rx while stopped");
endmodule : slpr_checker

// ### tb_top.sv
// Testbench joining the channel and the external master over the link.
// Assumes design files and checker compiled first; inputs move on falling edges.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
	$display("Error at %0t: value mismatch", $time); end end
module tb_top;
	logic core_clk = 0, nrst = 0, start = 0, stop_mode = 0, hs_osc_selected = 1;
	logic wake_enable_bit = 0, channel_start_bit = 0, channel_stop_bit = 0, master_mode = 0;
	logic data_wr = 0, data_rd = 0, ch1_rx_done = 0, ch1_data_rd = 0, busy, wake_cpu;
	logic channel_enabled_flag, buffer_full_flag, overrun_flag, ch1_buffer_full_flag;
	logic ch1_overrun_flag, low_power_receive_mode, sck_out, sck_oe;
	logic [3:0] channel_stop_reg = 4'h0;
	logic [7:0] prescaler_select_reg = 8'h00, rx_data, tx_byte = 8'h00, rx_exp = 8'h00;
	logic [15:0] channel_mode_reg = 16'h0000, channel_data_wr = 16'h0000, channel_data_reg;
	logic [31:0] seed = 32'hf736b7c0;
	logic [11:0] q_st[$];
	int q_half[$];
	int n_fail = 0, samples_checked = 0, cyc = 0, cnt = 0, seen = 0, n_wake = 0;
	slpr_link_if link ();
	slpr_device slpr_device_i (.*);
	slpr_master slpr_master_i (.*);
	slpr_checker slpr_checker_i (.sck(link.sck), .*);
	initial forever #25 core_clk = ~core_clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge core_clk);
		s = 0;
	endtask : pulse
	// Expectation order: low-power mode, full, overrun, ch1 full, byte
	task automatic frame(input logic [3:0] f, input logic rx);
		int i;
		seed = xs(seed);
		tx_byte = seed[7:0];
		if (rx) rx_exp = seed[7:0];
		q_st.push_back({f, rx_exp});
		pulse(start);
		for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
		repeat (12) @(negedge core_clk);
	endtask : frame
	task automatic end_sim;
		if (q_st.size() || q_half.size()) n_fail++;
		$display("Checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(negedge busy) begin
		repeat (8) @(posedge core_clk);
		#1;
		if (nrst && q_st.size()) `CHK({low_power_receive_mode, buffer_full_flag, overrun_flag,
			ch1_buffer_full_flag, rx_data}, q_st.pop_front())
	end
	// Half periods counted edge to edge; the first, partial one is skipped
	always @(sck_out) begin
		if (nrst && master_mode) begin
			if (seen > 0 && q_half.size()) `CHK(cnt, q_half.pop_front())
			seen++;
			cnt = 0;
		end
	end
	always @(posedge core_clk) begin
		cnt++;
		cyc++;
		if (wake_cpu === 1'b1) n_wake++;
		if (cyc == 10000) begin
			n_fail++;
			end_sim();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		int i, k, p, d;
		repeat (10) @(negedge core_clk);
		nrst = 1;
		@(negedge core_clk);
		pulse(channel_start_bit);
		`CHK(channel_enabled_flag, 1'b1)
		frame(4'h4, 1'b1);
		frame(4'h6, 1'b1);
		pulse(data_rd);
		`CHK(n_wake, 2)
		$display("Test run mode done");
		pulse(channel_stop_bit);
		pulse(channel_start_bit);
		stop_mode = 1;
		frame(4'h2, 1'b0);
		stop_mode = 0;
		$display("Test stop without wake done");
		pulse(channel_stop_bit);
		pulse(channel_start_bit);
		wake_enable_bit = 1;
		stop_mode = 1;
		pulse(ch1_rx_done);
		frame(4'he, 1'b1);
		pulse(data_rd);
		pulse(channel_stop_bit);
		`CHK(channel_enabled_flag, 1'b0)
		wake_enable_bit = 0;
		stop_mode = 0;
		pulse(ch1_rx_done);
		@(negedge core_clk);
		pulse(ch1_rx_done);
		repeat (3) @(negedge core_clk);
		`CHK(ch1_buffer_full_flag, 1'b1)
		`CHK(ch1_overrun_flag, 1'b1)
		`CHK(n_wake, 2)
		pulse(ch1_data_rd);
		$display("Test low-power receive done");
		master_mode = 1;
		for (k = 0; k < 5; k++) begin
			seed = xs(seed);
			p = (k == 4) ? 0 : int'(seed[1:0]);
			d = (k == 4) ? 127 : int'(seed[4:2]);
			channel_stop_reg = 4'hf;
			@(negedge core_clk);
			channel_stop_reg = 4'h0;
			// Unused field at its slowest so a wrong select shows at once
			channel_mode_reg = {seed[5], 15'h0000};
			prescaler_select_reg = seed[5] ? {p[3:0], 4'hf} : {4'hf, p[3:0]};
			pulse(channel_start_bit);
			channel_data_wr = {d[6:0], 9'h000};
			seen = 0;
			q_half.push_back((d + 1) << p);
			pulse(data_wr);
			`CHK(channel_data_reg[15:9], d[6:0])
			for (i = 0; i < 3000 && q_half.size(); i++) @(negedge core_clk);
			`CHK(sck_oe, 1'b1)
		end
		pulse(channel_stop_bit);
		@(negedge core_clk);
		`CHK(sck_oe, 1'b0)
		$display("Test clock generation done");
		end_sim();
	end
endmodule : tb_top
